// file: design/tuner_match_map.svh
`ifndef TUNER_MATCH_MAP_SVH
`define TUNER_MATCH_MAP_SVH

// Table geometry
`define TM_ENTRIES    64
`define TM_LAST_IDX   6'h3F
`define TM_IDX_W      6
// Frequency in kHz, bins of the coarse resolution
`define TM_FREQ_W     15
`define TM_BIN_W      11
`define TM_RES_KHZ    6'h1E
`define TM_NEAR_BINS  11'h001
// Entry payload and age stamp
`define TM_DATA_W     16
`define TM_STAMP_W    16
// Ratio in tenths: 3.0 limit and 1.5 goal
`define TM_SWR_W      8
`define TM_SWR_LIMIT  8'h1E
`define TM_SWR_GOOD   8'h0F

`endif

// file: design/tuner_match_pkg.sv
package tuner_match_pkg;

    // Controller states, Gray coded along the scan path
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_DONE = 2'b11
    } state_t;

    // Kind of table operation in flight
    typedef enum logic [1:0] {
        OP_SEED   = 2'b00,
        OP_RECALL = 2'b01,
        OP_STORE  = 2'b10
    } op_t;

endpackage : tuner_match_pkg

// file: design/freq_truncate.sv
`timescale 1ns/1ns
`default_nettype none
`include "tuner_match_map.svh"

module freq_truncate (
    input  wire logic [`TM_FREQ_W-1:0] freq_khz,
    output logic      [`TM_BIN_W-1:0]  freq_bin
);

    logic [5:0]            rem;
    logic [`TM_FREQ_W-1:0] quo;

    // Restoring division by the bin width drops the remainder
    always_comb begin
        rem = 6'h00;
        quo = '0;
        for (int i = `TM_FREQ_W - 1; i >= 0; i--) begin
            rem = {rem[4:0], freq_khz[i]};
            if (rem >= `TM_RES_KHZ) begin
                rem    = rem - `TM_RES_KHZ;
                quo[i] = 1'b1;
            end
        end
        freq_bin = quo[`TM_BIN_W-1:0];
    end

endmodule : freq_truncate
`default_nettype wire

// file: design/tuner_match_memory_table.sv
`timescale 1ns/1ns
`default_nettype none
`include "tuner_match_map.svh"

module tuner_match_memory_table (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic [`TM_FREQ_W-1:0] freq_khz,
    input  wire logic                  ant_port,
    input  wire logic                  atu_on,
    input  wire logic                  tune_start,
    input  wire logic                  tune_done,
    input  wire logic [`TM_SWR_W-1:0]  init_swr,
    input  wire logic [`TM_SWR_W-1:0]  final_swr,
    input  wire logic [`TM_DATA_W-1:0] result_data,
    input  wire logic                  clear_port,
    input  wire logic                  clear_sel,
    input  wire logic                  tx_key_pin,
    input  wire logic                  swr_high_pin,
    output logic                       busy,
    output logic                       seed_valid,
    output logic                       recall_apply,
    output logic      [`TM_DATA_W-1:0] net_data,
    output logic                       store_done,
    output logic                       match_fail,
    output logic                       table_full,
    output logic                       tx_inhibit,
    output logic                       atu_bypass
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    tuner_match_pkg::state_t state;
    tuner_match_pkg::op_t    op;
    logic                    ent_valid [`TM_ENTRIES];
    logic                    ent_port  [`TM_ENTRIES];
    logic                    ent_net   [`TM_ENTRIES];
    logic [`TM_BIN_W-1:0]    ent_bin   [`TM_ENTRIES];
    logic [`TM_DATA_W-1:0]   ent_data  [`TM_ENTRIES];
    logic [`TM_STAMP_W-1:0]  ent_stamp [`TM_ENTRIES];
    logic [`TM_BIN_W-1:0]    cur_bin;
    logic [`TM_BIN_W-1:0]    bin_l;
    logic                    port_l;
    logic [`TM_DATA_W-1:0]   data_l;
    logic [`TM_SWR_W-1:0]    init_l;
    logic [`TM_SWR_W-1:0]    final_l;
    logic [`TM_IDX_W-1:0]    scan_idx;
    logic                    exact_found;
    logic [`TM_IDX_W-1:0]    exact_idx;
    logic                    free_found;
    logic [`TM_IDX_W-1:0]    free_idx;
    logic                    best_found;
    logic [`TM_IDX_W-1:0]    best_idx;
    logic [`TM_BIN_W-1:0]    best_dist;
    logic [`TM_IDX_W-1:0]    old_idx;
    logic [`TM_STAMP_W-1:0]  old_stamp;
    logic [`TM_STAMP_W-1:0]  next_stamp;
    logic [`TM_IDX_W-1:0]    wr_idx;
    logic                    key_meta;
    logic                    key_sync;
    logic                    key_prev;
    logic                    alarm_meta;
    logic                    alarm_sync;
    logic                    key_rise;
    logic                    start_cmd;
    logic                    store_net;
    logic                    near_ok;
    logic                    all_valid;

    // Distance between two bins
    function automatic logic [`TM_BIN_W-1:0] bin_dist(
        input logic [`TM_BIN_W-1:0] a,
        input logic [`TM_BIN_W-1:0] b
    );
        bin_dist = (a > b) ? a - b : b - a;
    endfunction : bin_dist

    ////////////////////////////////////////////////////////////////////////
    // Frequency truncation
    freq_truncate u_trunc (
        .freq_khz (freq_khz),
        .freq_bin (cur_bin)
    );

    // Pin synchronisers for key and ratio alarm
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            key_meta   <= 1'b0;
            key_sync   <= 1'b0;
            key_prev   <= 1'b0;
            alarm_meta <= 1'b0;
            alarm_sync <= 1'b0;
        end else begin
            key_meta   <= tx_key_pin;
            key_sync   <= key_meta;
            key_prev   <= key_sync;
            alarm_meta <= swr_high_pin;
            alarm_sync <= alarm_meta;
        end
    end

    // Command decode; clear has priority, then store, seed, recall
    assign key_rise  = key_sync & ~key_prev;
    assign start_cmd = ~clear_port
                     & (tune_done | tune_start | (key_rise & atu_on));
    assign store_net = init_l < `TM_SWR_LIMIT;
    assign near_ok   = best_found && ent_net[best_idx]
                     && best_dist <= `TM_NEAR_BINS
                     && ent_port[best_idx] == port_l;
    // Exact hit, else next unused, else oldest
    assign wr_idx    = exact_found ? exact_idx
                     : free_found ? free_idx : old_idx;

    ////////////////////////////////////////////////////////////////////////
    // Control state machine and request latch
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state   <= tuner_match_pkg::ST_IDLE;
            op      <= tuner_match_pkg::OP_SEED;
            bin_l   <= '0;
            port_l  <= 1'b0;
            data_l  <= '0;
            init_l  <= '0;
            final_l <= '0;
        end else begin
            unique case (state)
                tuner_match_pkg::ST_IDLE: begin
                    if (start_cmd) begin
                        state   <= tuner_match_pkg::ST_SCAN;
                        op      <= tune_done ? tuner_match_pkg::OP_STORE
                                 : tune_start ? tuner_match_pkg::OP_SEED
                                 : tuner_match_pkg::OP_RECALL;
                        bin_l   <= cur_bin;
                        port_l  <= ant_port;
                        data_l  <= result_data;
                        init_l  <= init_swr;
                        final_l <= final_swr;
                    end
                end
                tuner_match_pkg::ST_SCAN: begin
                    if (scan_idx == `TM_LAST_IDX) begin
                        state <= tuner_match_pkg::ST_DONE;
                    end
                end
                tuner_match_pkg::ST_DONE: begin
                    state <= tuner_match_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan of one entry per cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn || state == tuner_match_pkg::ST_IDLE) begin
            scan_idx    <= '0;
            exact_found <= 1'b0;
            exact_idx   <= '0;
            free_found  <= 1'b0;
            free_idx    <= '0;
            best_found  <= 1'b0;
            best_idx    <= '0;
            best_dist   <= '1;
            old_idx     <= '0;
            old_stamp   <= '1;
        end else if (state == tuner_match_pkg::ST_SCAN) begin
            scan_idx <= scan_idx + 6'h01;
            if (ent_valid[scan_idx]) begin
                // Same port and bin: the only possible hit
                if (ent_port[scan_idx] == port_l
                        && ent_bin[scan_idx] == bin_l) begin
                    exact_found <= 1'b1;
                    exact_idx   <= scan_idx;
                end
                // Nearest stored point over all entries
                if (bin_dist(ent_bin[scan_idx], bin_l) < best_dist) begin
                    best_found <= 1'b1;
                    best_idx   <= scan_idx;
                    best_dist  <= bin_dist(ent_bin[scan_idx], bin_l);
                end
                // Lowest stamp marks the oldest entry
                if (ent_stamp[scan_idx] < old_stamp) begin
                    old_idx   <= scan_idx;
                    old_stamp <= ent_stamp[scan_idx];
                end
            end else if (!free_found) begin
                free_found <= 1'b1;
                free_idx   <= scan_idx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry store, port clear and allocation stamp
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            next_stamp <= '0;
            for (int i = 0; i < `TM_ENTRIES; i++) begin
                ent_valid[i] <= 1'b0;
                ent_port[i]  <= 1'b0;
                ent_net[i]   <= 1'b0;
                ent_bin[i]   <= '0;
                ent_data[i]  <= '0;
                ent_stamp[i] <= '0;
            end
        end else if (state == tuner_match_pkg::ST_IDLE && clear_port) begin
            for (int i = 0; i < `TM_ENTRIES; i++) begin
                if (ent_port[i] == clear_sel) begin
                    ent_valid[i] <= 1'b0;
                end
            end
        end else if (state == tuner_match_pkg::ST_DONE
                && op == tuner_match_pkg::OP_STORE) begin
            ent_valid[wr_idx] <= 1'b1;
            ent_port[wr_idx]  <= port_l;
            ent_net[wr_idx]   <= store_net;
            ent_bin[wr_idx]   <= bin_l;
            ent_data[wr_idx]  <= data_l;
            if (!exact_found) begin
                ent_stamp[wr_idx] <= next_stamp;
                next_stamp        <= next_stamp + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result outputs
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            busy         <= 1'b0;
            seed_valid   <= 1'b0;
            recall_apply <= 1'b0;
            net_data     <= '0;
            store_done   <= 1'b0;
            match_fail   <= 1'b0;
        end else begin
            busy         <= (state == tuner_match_pkg::ST_IDLE)
                          ? start_cmd : (state != tuner_match_pkg::ST_DONE);
            seed_valid   <= 1'b0;
            recall_apply <= 1'b0;
            store_done   <= 1'b0;
            if (state == tuner_match_pkg::ST_DONE) begin
                unique case (op)
                    tuner_match_pkg::OP_SEED: begin
                        seed_valid <= near_ok;
                        if (near_ok) begin
                            net_data <= ent_data[best_idx];
                        end
                    end
                    tuner_match_pkg::OP_RECALL: begin
                        recall_apply <= near_ok;
                        if (near_ok) begin
                            net_data <= ent_data[best_idx];
                        end
                    end
                    tuner_match_pkg::OP_STORE: begin
                        store_done <= 1'b1;
                        match_fail <= store_net
                                    && final_l > `TM_SWR_GOOD;
                    end
                    default: begin
                        store_done <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Table full flag
    always_comb begin
        all_valid = 1'b1;
        for (int i = 0; i < `TM_ENTRIES; i++) begin
            all_valid = all_valid & ent_valid[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            table_full <= 1'b0;
        end else begin
            table_full <= all_valid;
        end
    end

    // Over-ratio protection; bypass held until the next tune start
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tx_inhibit <= 1'b0;
            atu_bypass <= 1'b0;
        end else begin
            tx_inhibit <= alarm_sync;
            if (alarm_sync) begin
                atu_bypass <= 1'b1;
            end else if (state == tuner_match_pkg::ST_IDLE && start_cmd
                    && tune_start && !tune_done) begin
                atu_bypass <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    int hit_count;
    int port_count;
    logic clear_sel_l;

    // Port of the clear taken on the previous edge
    always_ff @(posedge ref_clk) begin
        clear_sel_l <= resetn ? clear_sel : 1'b0;
    end

    always_comb begin
        hit_count  = 0;
        port_count = 0;
        for (int i = 0; i < `TM_ENTRIES; i++) begin
            if (ent_valid[i] && ent_port[i] == port_l
                    && ent_bin[i] == bin_l) begin
                hit_count++;
            end
            if (ent_valid[i] && ent_port[i] == clear_sel_l) begin
                port_count++;
            end
        end
    end

    sequence scan_begin;
        state == tuner_match_pkg::ST_IDLE && start_cmd;
    endsequence
    sequence scan_end;
        state == tuner_match_pkg::ST_DONE ##1 !busy;
    endsequence

    scan_length_a: assert property (scan_begin |-> ##65 scan_end)
        else $error("scan did not end after 64 entries");
    alarm_protect_a: assert property ($rose(alarm_sync) |=>
        tx_inhibit && atu_bypass)
        else $error("over-ratio did not inhibit and bypass");
    net_store_a: assert property (state == tuner_match_pkg::ST_DONE
        && op == tuner_match_pkg::OP_STORE && store_net |=> ent_net[$past(wr_idx)])
        else $error("tuned network not stored as network");
    raw_store_a: assert property (state == tuner_match_pkg::ST_DONE
        && op == tuner_match_pkg::OP_STORE && !store_net
        |=> !ent_net[$past(wr_idx)] && !match_fail)
        else $error("raw readings not stored as raw");
    single_entry_a: assert property (store_done |-> hit_count == 1)
        else $error("duplicate entry for port and frequency");
    seed_gate_a: assert property (seed_valid |-> $past(best_dist) <=
        `TM_NEAR_BINS && ent_port[best_idx] == port_l)
        else $error("seed from a far or foreign entry");
    port_clear_a: assert property (state == tuner_match_pkg::ST_IDLE
        && clear_port |=> port_count == 0)
        else $error("port clear left entries");
    match_goal_a: assert property (store_done && store_net
        |-> match_fail == (final_l > `TM_SWR_GOOD))
        else $error("match goal flag wrong");
    recall_pulse_a: assert property (recall_apply |->
        op == tuner_match_pkg::OP_RECALL && $fell(busy) ##1 !recall_apply)
        else $error("recall not a single pulse");

endmodule : tuner_match_memory_table
`default_nettype wire

// file: testbench/tune_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "tuner_match_map.svh"

module tune_engine_model (
    input  wire logic                  ref_clk,
    output logic                       tune_start,
    output logic                       tune_done,
    output logic      [`TM_SWR_W-1:0]  init_swr,
    output logic      [`TM_SWR_W-1:0]  final_swr,
    output logic      [`TM_DATA_W-1:0] result_data,
    output logic                       tx_key_pin,
    output logic                       swr_high_pin
);
    // Quiet lines at time zero
    initial begin
        tune_start   = 1'h0;
        tune_done    = 1'h0;
        init_swr     = 8'h00;
        final_swr    = 8'h00;
        result_data  = 16'h0000;
        tx_key_pin   = 1'h0;
        swr_high_pin = 1'h0;
    end

    // One-cycle request for a seeded search
    task automatic start_tune();
        @(posedge ref_clk);
        tune_start <= 1'h1;
        @(posedge ref_clk);
        tune_start <= 1'h0;
    endtask : start_tune

    // Result after a search of dly cycles; raw data at or above limit, no search
    task automatic finish_tune(input logic [7:0] i_swr, input logic [7:0] f_swr,
                               input logic [15:0] data, input int dly);
        repeat (dly) @(posedge ref_clk);
        @(posedge ref_clk);
        tune_done   <= 1'h1;
        init_swr    <= i_swr;
        final_swr   <= (i_swr >= `TM_SWR_LIMIT)
                     ? i_swr : f_swr;
        result_data <= data;
        @(posedge ref_clk);
        // Released lines show the inverse, not a stale value
        tune_done   <= 1'h0;
        init_swr    <= ~i_swr;
        final_swr   <= ~f_swr;
        result_data <= ~data;
    endtask : finish_tune

    // Key and detector alarm pins
    task automatic set_pins(input logic key, input logic alarm);
        @(posedge ref_clk);
        tx_key_pin   <= key;
        swr_high_pin <= alarm;
    endtask : set_pins
endmodule : tune_engine_model
`default_nettype wire

// file: testbench/test_tuner_match_memory_table.sv
`timescale 1ns/1ns
`default_nettype none
`include "tuner_match_map.svh"

module test_tuner_match_memory_table;
    logic                  ref_clk;
    logic                  resetn;
    logic [`TM_FREQ_W-1:0] freq_khz;
    logic                  ant_port;
    logic                  atu_on;
    logic                  clear_port;
    logic                  clear_sel;
    logic                  tune_start;
    logic                  tune_done;
    logic [`TM_SWR_W-1:0]  init_swr;
    logic [`TM_SWR_W-1:0]  final_swr;
    logic [`TM_DATA_W-1:0] result_data;
    logic                  tx_key_pin;
    logic                  swr_high_pin;
    logic                  busy;
    logic                  seed_valid;
    logic                  recall_apply;
    logic [`TM_DATA_W-1:0] net_data;
    logic                  store_done;
    logic                  match_fail;
    logic                  table_full;
    logic                  tx_inhibit;
    logic                  atu_bypass;
    int                    compares;
    int                    miscompares;

    tuner_match_memory_table tuner_match_memory_table_i (
        .ref_clk, .resetn, .freq_khz, .ant_port, .atu_on, .tune_start,
        .tune_done, .init_swr, .final_swr, .result_data, .clear_port,
        .clear_sel, .tx_key_pin, .swr_high_pin, .busy, .seed_valid,
        .recall_apply, .net_data, .store_done, .match_fail, .table_full,
        .tx_inhibit, .atu_bypass
    );

    tune_engine_model tune_engine_model_i (
        .ref_clk, .tune_start, .tune_done, .init_swr, .final_swr,
        .result_data, .tx_key_pin, .swr_high_pin
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock
    always #4 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    // Compare, report and close
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // Follow one operation until busy drops; collect result pulses
    task automatic wait_op(input bit may_idle, output logic [2:0] seen,
                           output logic [15:0] data);
        int n;
        bit was_busy;
        seen     = 3'h0;
        data     = 16'h0000;
        was_busy = 1'h0;
        for (n = 0; n < 90; n++) begin
            @(posedge ref_clk);
            #1;
            if (seed_valid === 1'h1 || recall_apply === 1'h1)
                data = net_data;
            seen = seen | {store_done === 1'h1, recall_apply === 1'h1,
                           seed_valid === 1'h1};
            if (busy === 1'h1)
                was_busy = 1'h1;
            else if (was_busy)
                break;
        end
        if (n == 90 && !may_idle) begin
            check("operation_end", 16'h0000, 16'h0001);
            give_verdict();
        end
        @(posedge ref_clk);
        #1;
    endtask : wait_op

    // Tune result written to the table
    task automatic store(input logic [14:0] f, input logic p,
                         input logic [7:0] i_swr, input logic [7:0] f_swr,
                         input logic [15:0] d, input int dly);
        logic [2:0]  seen;
        logic [15:0] data;
        @(posedge ref_clk);
        freq_khz <= f;
        ant_port <= p;
        tune_engine_model_i.finish_tune(i_swr, f_swr, d, dly);
        wait_op(1'h0, seen, data);
        check("store_done", {15'h0000, seen[2]}, 16'h0001);
    endtask : store

    // Seed lookup at tune start
    task automatic lookup(input logic [14:0] f, input logic p,
                          input logic hit, input logic [15:0] d);
        logic [2:0]  seen;
        logic [15:0] data;
        @(posedge ref_clk);
        freq_khz <= f;
        ant_port <= p;
        tune_engine_model_i.start_tune();
        wait_op(1'h0, seen, data);
        check("seed_valid", {15'h0, seen[0]}, {15'h0, hit});
        if (hit)
            check("seed_data", data, d);
    endtask : lookup

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic network_scenario();
        store(15'h2EE0, 1'h0, 8'h14, 8'h10, 16'h1234, 0);
        check("match_fail_set", {15'h0, match_fail}, 16'h0001);
        store(15'h2EEA, 1'h0, 8'h14, 8'h0F, 16'h5678, 20);
        check("match_fail_clr", {15'h0, match_fail}, 16'h0000);
        lookup(15'h2EF4, 1'h0, 1'h1, 16'h5678);
        lookup(15'h2EE0, 1'h1, 1'h0, 16'h0000);
    endtask : network_scenario

    task automatic raw_scenario();
        store(15'h3A98, 1'h0, 8'h1E, 8'h0A, 16'h9ABC, 0);
        lookup(15'h3A98, 1'h0, 1'h0, 16'h0000);
    endtask : raw_scenario

    task automatic recall_scenario(input logic on);
        logic [2:0]  seen;
        logic [15:0] data;
        @(posedge ref_clk);
        atu_on   <= on;
        freq_khz <= 15'h2EE0;
        ant_port <= 1'h0;
        tune_engine_model_i.set_pins(1'h1, 1'h0);
        wait_op(1'h1, seen, data);
        check("recall_apply", {15'h0, seen[1]}, {15'h0, on});
        check("recall_seed", {15'h0000, seen[0]}, 16'h0000);
        if (on)
            check("recall_data", data, 16'h5678);
        tune_engine_model_i.set_pins(1'h0, 1'h0);
        repeat (4) @(posedge ref_clk);
        atu_on <= 1'h0;
    endtask : recall_scenario

    task automatic alarm_scenario();
        tune_engine_model_i.set_pins(1'h0, 1'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        check("tx_early", {15'h0, tx_inhibit}, 16'h0000);
        @(posedge ref_clk);
        #1;
        check("tx_inhibit", {15'h0000, tx_inhibit}, 16'h0001);
        check("atu_bypass", {15'h0000, atu_bypass}, 16'h0001);
        tune_engine_model_i.set_pins(1'h0, 1'h0);
        repeat (5) @(posedge ref_clk);
        #1;
        check("tx_inhibit_off", {15'h0, tx_inhibit}, 16'h0000);
        check("bypass_held", {15'h0000, atu_bypass}, 16'h0001);
        lookup(15'h2EE0, 1'h0, 1'h1, 16'h5678);
        check("bypass_clear", {15'h0000, atu_bypass}, 16'h0000);
    endtask : alarm_scenario

    task automatic fill_scenario();
        int k;
        for (k = 0; k < 62; k++) begin
            if (k == 61)
                check("not_full", {15'h0, table_full}, 16'h0);
            store(15'(1000 + 90 * k), k[0], 8'h14, 8'h0B,
                  16'(16'hA000 + k), 0);
        end
        check("full", {15'h0, table_full}, 16'h1);
        store(15'h2328, 1'h0, 8'h14, 8'h0B, 16'hB000, 0);
        lookup(15'h2EE0, 1'h0, 1'h0, 16'h0000);
        lookup(15'h03E8, 1'h0, 1'h1, 16'hA000);
        lookup(15'h2328, 1'h0, 1'h1, 16'hB000);
    endtask : fill_scenario

    task automatic clear_scenario();
        @(posedge ref_clk);
        clear_port <= 1'h1;
        clear_sel  <= 1'h1;
        @(posedge ref_clk);
        clear_port <= 1'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("full_after_clear", {15'h0, table_full}, 16'h0);
        lookup(15'h0442, 1'h1, 1'h0, 16'h0000);
        lookup(15'h049C, 1'h0, 1'h1, 16'hA002);
        store(15'h0442, 1'h1, 8'h14, 8'h0B, 16'hC000, 0);
        lookup(15'h0442, 1'h1, 1'h1, 16'hC000);
        check("still_free", {15'h0000, table_full}, 16'h0000);
    endtask : clear_scenario

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        ref_clk     = 1'h0;
        resetn      = 1'h0;
        freq_khz    = 15'h0000;
        ant_port    = 1'h0;
        atu_on      = 1'h0;
        clear_port  = 1'h0;
        clear_sel   = 1'h0;
        compares    = 0;
        miscompares = 0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'h1;
        @(posedge ref_clk);
        #1;
        check("reset_outputs", {9'h000, busy, seed_valid, recall_apply,
              store_done, table_full, tx_inhibit, atu_bypass},
              16'h0000);
        network_scenario();
        raw_scenario();
        recall_scenario(1'h1);
        recall_scenario(1'h0);
        alarm_scenario();
        fill_scenario();
        clear_scenario();
        give_verdict();
    end
endmodule : test_tuner_match_memory_table
`default_nettype wire
